// File: hw/ebt_pkg.sv
// ebt_pkg: shared constants and carriers for the eeprom block transfer engine
// assumes a single 100 MHz core clock and a synchronous word-wide eeprom/register port
package ebt_pkg;
  localparam int unsigned CLK_MHZ       = 100;                 // core clock rate
  localparam int unsigned WORD_W        = 16;                  // data word width
  localparam int unsigned BLK_WORDS     = 64;                  // words per block
  localparam int unsigned BLK_WORD_W    = 6;                   // word index width
  localparam int unsigned BLKNUM_W      = 8;                   // block number width
  localparam int unsigned ADDR_W        = 16;                  // register address width
  localparam int unsigned EE_ADDR_W     = 14;                  // eeprom word address width
  localparam int unsigned FIFO_DEPTH    = 4;                   // words buffered in flight
  // variant limits, indexed by variant code 0..2
  localparam logic [7:0]  MAX_START_V0  = 8'h09;               // start block limit, small
  localparam logic [7:0]  MAX_START_V1  = 8'h5F;               // start block limit, mid
  localparam logic [7:0]  MAX_START_V2  = 8'hFF;               // start block limit, large
  localparam logic [7:0]  MAX_COUNT_V0  = 8'h02;               // block count limit, small
  localparam logic [7:0]  MAX_COUNT_V1  = 8'h08;               // block count limit, mid
  localparam logic [7:0]  MAX_COUNT_V2  = 8'hFF;               // block count limit, large
  // write time per block and its cycle count
  localparam int unsigned WR_MS_SMALL   = 20;                  // ms per block, small variant
  localparam int unsigned WR_MS_OTHER   = 5;                   // ms per block, others
  localparam int unsigned WR_CYC_SMALL  = WR_MS_SMALL * 1000 * CLK_MHZ * 1000 / 1000;
  localparam int unsigned WR_CYC_OTHER  = WR_MS_OTHER * 1000 * CLK_MHZ * 1000 / 1000;
  // read may add less than 1 ms per block
  localparam int unsigned RD_MS_MAX     = 1;                   // ms per block, upper bound
  localparam int unsigned RD_CYC_MAX    = RD_MS_MAX * 1000 * CLK_MHZ - 1;
  // endurance limits
  localparam logic [16:0] ENDUR_SMALL   = 17'h186A0;           // 100,000 write events
  localparam logic [16:0] ENDUR_OTHER   = 17'h02710;           // 10,000 write events
  localparam logic [1:0]  VARIANT_RST   = 2'h0;                // variant after reset

  // one command as issued by the program
  typedef struct packed {
    logic [BLKNUM_W-1:0] first_operand;       // eeprom start block
    logic [BLKNUM_W-1:0] block_count_operand; // blocks to move
    logic [ADDR_W-1:0]   dt_start;            // data register start address
  } ebt_cmd_t;

  // one word on its way between the two memories
  typedef struct packed {
    logic [ADDR_W-1:0]   dt_addr;             // register-side address
    logic [EE_ADDR_W-1:0] ee_addr;            // eeprom-side address
    logic [WORD_W-1:0]   data;                // payload
  } ebt_word_t;
endpackage

// File: hw/ebt_fifo.sv
// ebt_fifo: small flip-flop fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/10ps
module ebt_fifo #(
  parameter int unsigned WIDTH = 46,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];   // storage
  logic [PW-1:0]    wp_r;            // write index
  logic [PW-1:0]    rp_r;            // read index
  logic [PW:0]      cnt_r;           // fill level
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_r != (PW+1)'(DEPTH));   // honest full
  assign out_valid = (cnt_r != '0);            // honest empty
  assign out_data  = mem_r[rp_r];

  // storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// File: hw/ebt_top.sv
// ebt_top: eeprom block transfer engine between data registers and eeprom
// assumes register and eeprom ports answer with one-cycle read latency and accept
// writes on a strobe; eeprom write completion is timed by a fixed per-block cycle count, not a busy pin
`timescale 1ns/10ps

// Operation
// [RL1] read repeats every scan while enabled
// [RL2] write runs once per enable rising edge
// [RL3] enable out flag set after execution
// [RL4] block is sixty-four 16-bit consecutive registers
// [RL5] start block within variant range
// [RL6] block count within variant range
// [RL7] each written block adds write time
// [RL8] each read block under one millisecond
// [RL9] endurance 100,000 small, else 10,000
// [RL10] power-down and mode change count writes
// [RL11] program fixes start or count constant
// [RL12] read destination is data register area
// [RL13] write source is data register address
// [RL14] program reserves 64 destination registers
// [RL15] program reads only valid eeprom data
// [RL16] eeprom written only on command execution
// [RL17] power loss saves retained area
// [RL18] program limits write command frequency
// [RL19] all blocks done before enable out
module ebt_top (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic [1:0]                  variant,          // 0 small, 1 mid, 2 large
  input  wire logic                        scan_tick,        // one pulse per scan
  input  wire logic                        eeprom_block_read,  // read enable level
  input  wire logic                        eeprom_block_write, // write enable level
  input  wire ebt_pkg::ebt_cmd_t           cmd,              // operands
  input  wire logic                        power_fail,       // supply dropping (pin)
  input  wire logic                        to_program_mode,  // run to program change
  input  wire ebt_pkg::ebt_cmd_t           retain_cmd,       // retained area geometry
  output logic                             enable_out_flag,  // command executed
  output logic                             busy,             // transfer in progress
  output logic                             cmd_error,        // operand out of range
  output logic                             endurance_spent,  // write count exhausted
  output logic [16:0]                      write_events,     // events consumed
  // data register area port
  output logic                             dt_rd,
  output logic                             dt_wr,
  output logic [ebt_pkg::ADDR_W-1:0]       dt_addr,
  output logic [ebt_pkg::WORD_W-1:0]       dt_wdata,
  input  wire logic [ebt_pkg::WORD_W-1:0]  dt_rdata,
  // eeprom port
  output logic                             ee_rd,
  output logic                             ee_wr,
  output logic [ebt_pkg::EE_ADDR_W-1:0]    ee_addr,
  output logic [ebt_pkg::WORD_W-1:0]       ee_wdata,
  input  wire logic [ebt_pkg::WORD_W-1:0]  ee_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {EBT_IDLE, EBT_FETCH, EBT_DRAIN, EBT_PROG, EBT_DONE} ebt_st_t;

  // variant limit lookups, used by the operand checks
  function automatic logic [7:0] ebt_max_start(input logic [1:0] v);
    unique case (v)
      2'h0:    ebt_max_start = ebt_pkg::MAX_START_V0;
      2'h1:    ebt_max_start = ebt_pkg::MAX_START_V1;
      default: ebt_max_start = ebt_pkg::MAX_START_V2;
    endcase
  endfunction
  function automatic logic [7:0] ebt_max_count(input logic [1:0] v);
    unique case (v)
      2'h0:    ebt_max_count = ebt_pkg::MAX_COUNT_V0;
      2'h1:    ebt_max_count = ebt_pkg::MAX_COUNT_V1;
      default: ebt_max_count = ebt_pkg::MAX_COUNT_V2;
    endcase
  endfunction

  ebt_st_t                       st_r;          // sequencer state
  logic                          is_write_r;    // direction of current run
  logic                          is_save_r;     // run is a power-down save
  ebt_pkg::ebt_cmd_t             run_r;         // latched operands
  logic [7:0]                    blk_r;         // blocks finished
  logic [5:0]                    src_idx_r;     // word fetched within block
  logic [5:0]                    dst_idx_r;     // word delivered within block
  logic                          fetch_pend_r;  // source word on its bus
  logic                          fetch_last_r;  // fetch of whole block issued
  logic [21:0]                   wait_r;        // write time counter
  logic                          wr_en_d_r;     // last write enable
  logic [2:0]                    pf_sync_r;     // power fail synchroniser
  logic                          pf_seen_r;     // save already done
  logic                          range_ok;
  logic                          wr_edge;
  logic                          pf_level;
  ebt_pkg::ebt_word_t            f_in;
  logic                          f_in_ready;
  ebt_pkg::ebt_word_t            f_out;
  logic                          f_out_valid;
  logic                          f_out_ready;
  logic [21:0]                   wr_cycles;

  ////////////////////////////////////////////////////////////////////////////
  // operand checks against the variant table
  assign range_ok = (cmd.first_operand <= ebt_max_start(variant))                  // RL5
                 && (cmd.block_count_operand != 8'h00)
                 && (cmd.block_count_operand <= ebt_max_count(variant));           // RL6
  assign wr_edge   = eeprom_block_write && !wr_en_d_r;                             // RL2
  assign pf_level  = pf_sync_r[1] && pf_sync_r[2];   // both late stages agree
  assign wr_cycles = (variant == 2'h0) ? 22'(ebt_pkg::WR_CYC_SMALL)
                                       : 22'(ebt_pkg::WR_CYC_OTHER);               // RL7

  // power fail pin passes three stages before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pf_sync_r <= '0;
    end else begin
      pf_sync_r <= {pf_sync_r[1:0], power_fail};
    end
  end

  // edge memory for the one-shot write command
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_en_d_r <= 1'b0;
    end else begin
      wr_en_d_r <= eeprom_block_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo feed: source side word (register for writes, eeprom for reads)
  always_comb begin
    f_in.data    = is_write_r ? dt_rdata : ee_rdata;
    f_in.dt_addr = run_r.dt_start + ebt_pkg::ADDR_W'({blk_r, src_idx_r - 6'h01});
    f_in.ee_addr = ebt_pkg::EE_ADDR_W'({run_r.first_operand, 6'h00})
                 + ebt_pkg::EE_ADDR_W'({blk_r, src_idx_r - 6'h01});
  end
  assign f_out_ready = (st_r == EBT_FETCH) || (st_r == EBT_DRAIN);

  ebt_fifo #(
    .WIDTH ($bits(ebt_pkg::ebt_word_t)),
    .DEPTH (ebt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (f_in),
    .in_valid  (fetch_pend_r),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: fetch a block through the fifo, then program time for writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r         <= EBT_IDLE;
      is_write_r   <= 1'b0;
      is_save_r    <= 1'b0;
      run_r        <= '0;
      blk_r        <= '0;
      src_idx_r    <= '0;
      dst_idx_r    <= '0;
      fetch_pend_r <= 1'b0;
      fetch_last_r <= 1'b0;
      wait_r       <= '0;
      pf_seen_r    <= 1'b0;
      cmd_error    <= 1'b0;
      enable_out_flag <= 1'b0;
    end else begin
      unique case (st_r)
        EBT_IDLE: begin
          fetch_last_r <= 1'b0;
          src_idx_r    <= '0;
          dst_idx_r    <= '0;
          blk_r        <= '0;
          if (pf_level && !pf_seen_r) begin                                        // RL17
            pf_seen_r  <= 1'b1;
            is_write_r <= 1'b1;
            is_save_r  <= 1'b1;
            run_r      <= retain_cmd;
            st_r       <= EBT_FETCH;
          end else if (wr_edge) begin                                              // RL16
            cmd_error  <= !range_ok;
            is_write_r <= 1'b1;
            is_save_r  <= 1'b0;
            run_r      <= cmd;
            st_r       <= range_ok ? EBT_FETCH : EBT_IDLE;
          end else if (eeprom_block_read && scan_tick) begin                       // RL1
            cmd_error  <= !range_ok;
            is_write_r <= 1'b0;
            is_save_r  <= 1'b0;
            run_r      <= cmd;
            st_r       <= range_ok ? EBT_FETCH : EBT_IDLE;
          end
          if (!eeprom_block_read && !eeprom_block_write) begin
            enable_out_flag <= 1'b0;   // flag follows the enable chain
          end
        end
        EBT_FETCH: begin
          // a read every other cycle; sink pops fall in the gaps
          fetch_pend_r <= dt_rd || ee_rd;   // word lands a cycle after its strobe
          if (!fetch_last_r && !dt_rd && !ee_rd && f_in_ready) begin
            src_idx_r    <= src_idx_r + 6'h01;                                     // RL4
            fetch_last_r <= (src_idx_r == 6'h3F);
          end
          if (f_out_valid) begin
            dst_idx_r <= dst_idx_r + 6'h01;
            if (dst_idx_r == 6'h3F) begin
              wait_r       <= is_write_r ? wr_cycles : 22'h000001;
              st_r         <= is_write_r ? EBT_PROG : EBT_DRAIN;
              fetch_pend_r <= 1'b0;
            end
          end
        end
        EBT_DRAIN: begin
          st_r <= EBT_PROG;   // read path: no program time
        end
        EBT_PROG: begin
          wait_r <= wait_r - 22'h000001;
          if (wait_r == 22'h000001) begin
            blk_r        <= blk_r + 8'h01;
            src_idx_r    <= '0;
            dst_idx_r    <= '0;
            fetch_last_r <= 1'b0;
            if (blk_r + 8'h01 == run_r.block_count_operand) begin                  // RL19
              st_r <= EBT_DONE;
            end else begin
              st_r <= EBT_FETCH;
            end
          end
        end
        EBT_DONE: begin
          enable_out_flag <= !is_save_r;                                           // RL3
          st_r            <= EBT_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory strobes: source reads while fetching, sink writes on fifo pop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dt_rd <= 1'b0; dt_wr <= 1'b0; ee_rd <= 1'b0; ee_wr <= 1'b0;
      dt_addr <= '0; dt_wdata <= '0; ee_addr <= '0; ee_wdata <= '0;
    end else begin
      dt_rd <= 1'b0;
      ee_rd <= 1'b0;
      dt_wr <= 1'b0;
      ee_wr <= 1'b0;
      if (st_r == EBT_FETCH && !fetch_last_r && !dt_rd && !ee_rd && f_in_ready) begin
        dt_rd   <= is_write_r;                                                     // RL13
        ee_rd   <= !is_write_r;
        dt_addr <= run_r.dt_start + ebt_pkg::ADDR_W'({blk_r, src_idx_r});
        ee_addr <= ebt_pkg::EE_ADDR_W'({run_r.first_operand, 6'h00})
                 + ebt_pkg::EE_ADDR_W'({blk_r, src_idx_r});
      end else if (f_out_valid && f_out_ready) begin
        ee_wr    <= is_write_r;                                                    // RL16
        dt_wr    <= !is_write_r;                                                   // RL12
        ee_addr  <= f_out.ee_addr;
        dt_addr  <= f_out.dt_addr;
        ee_wdata <= f_out.data;
        dt_wdata <= f_out.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // endurance accounting: write commands, saves and mode changes consume one; two in the same cycle consume one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_events    <= '0;
      endurance_spent <= 1'b0;
      busy            <= 1'b0;
    end else begin
      busy <= (st_r != EBT_IDLE);
      if ((st_r == EBT_DONE && is_write_r) || to_program_mode) begin               // RL10
        write_events <= write_events + 17'h00001;
      end
      endurance_spent <= write_events >= ((variant == 2'h0) ? ebt_pkg::ENDUR_SMALL
                                                            : ebt_pkg::ENDUR_OTHER); // RL9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_rd_scan;
    @(posedge core_clk) disable iff (rst)
      (st_r == EBT_IDLE && !pf_level && !wr_edge && eeprom_block_read && scan_tick && range_ok)
      |=> (st_r == EBT_FETCH);
  endproperty
  a_rd_scan: assert property (p_rd_scan) else $error("read not started"); // RL1
  property p_wr_once;
    @(posedge core_clk) disable iff (rst)
      ee_wr |-> ($past(st_r) == EBT_FETCH && is_write_r);
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("stray eeprom write"); // RL16
  property p_eno;
    @(posedge core_clk) disable iff (rst)
      (st_r == EBT_DONE && !is_save_r) |=> enable_out_flag;
  endproperty
  a_eno: assert property (p_eno) else $error("enable out missing"); // RL3
  property p_range;
    @(posedge core_clk) disable iff (rst)
      (st_r == EBT_IDLE && !pf_level && (wr_edge || (eeprom_block_read && scan_tick)) && !range_ok)
      |=> cmd_error && st_r == EBT_IDLE;
  endproperty
  a_range: assert property (p_range) else $error("bad operands accepted"); // RL5
  property p_count;
    @(posedge core_clk) disable iff (rst)
      (st_r == EBT_DONE) |-> (blk_r == run_r.block_count_operand);
  endproperty
  a_count: assert property (p_count) else $error("blocks left undone"); // RL19
  property p_wtime;
    @(posedge core_clk) disable iff (rst)
      (st_r == EBT_PROG && is_write_r && $past(st_r) == EBT_FETCH)
      |-> (wait_r == wr_cycles);
  endproperty
  a_wtime: assert property (p_wtime) else $error("wrong write time"); // RL7
  property p_rfast;
    @(posedge core_clk) disable iff (rst)
      (st_r == EBT_DRAIN) |=> (st_r == EBT_PROG) ##1 (st_r != EBT_PROG);
  endproperty
  a_rfast: assert property (p_rfast) else $error("read block too slow"); // RL8
  property p_events;
    @(posedge core_clk) disable iff (rst)
      (to_program_mode) |=> (write_events == $past(write_events) + 17'h00001);
  endproperty
  a_events: assert property (p_events) else $error("event not counted"); // RL10
endmodule

// File: verif/ebt_mem_model.sv
// ebt_mem_model: register area and eeprom array facing the engine
// assumes one-cycle read latency and single-cycle write strobes
`timescale 1ns/10ps
module ebt_mem_model (
  input  wire logic                         core_clk,
  input  wire logic                         dt_rd,
  input  wire logic                         dt_wr,
  input  wire logic [ebt_pkg::ADDR_W-1:0]   dt_addr,
  input  wire logic [ebt_pkg::WORD_W-1:0]   dt_wdata,
  output logic      [ebt_pkg::WORD_W-1:0]   dt_rdata,
  input  wire logic                         ee_rd,
  input  wire logic                         ee_wr,
  input  wire logic [ebt_pkg::EE_ADDR_W-1:0] ee_addr,
  input  wire logic [ebt_pkg::WORD_W-1:0]   ee_wdata,
  output logic      [ebt_pkg::WORD_W-1:0]   ee_rdata
);
  logic [ebt_pkg::WORD_W-1:0] reg_mem [0:65535];  // register area words
  logic [ebt_pkg::WORD_W-1:0] eep_mem [0:16383];  // eeprom words, preloaded by the bench
  ////////////////////////////////////////////////////////////////////////////////
  // register side: data one cycle late, inverted when idle
  always @(posedge core_clk) begin
    if (dt_wr) begin
      reg_mem[dt_addr] <= dt_wdata;
    end
    dt_rdata <= dt_rd ? reg_mem[dt_addr] : ~dt_rdata;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // eeprom side: bench-preloaded words plus engine writes, data one cycle late, inverted when idle
  always @(posedge core_clk) begin
    if (ee_wr) begin
      eep_mem[ee_addr] <= ee_wdata;
    end
    ee_rdata <= ee_rd ? eep_mem[ee_addr] : ~ee_rdata;
  end
endmodule

// File: verif/tb_eeprom_block_transfer.sv
// tb_eeprom_block_transfer: self-checking bench for the block transfer engine
// assumes ebt_mem_model as far side
`timescale 1ns/10ps
module tb_eeprom_block_transfer;
  logic               core_clk = 1'b0;             // 100 MHz
  logic               rst = 1'b1;                  // sync, active high
  logic [1:0]         variant = 2'h0;              // size variant
  logic               scan_tick = 1'b0;            // scan pulse
  logic               eeprom_block_read = 1'b0;    // read enable level
  logic               eeprom_block_write = 1'b0;   // write enable level
  logic               to_program_mode = 1'b0;      // mode change pulse
  ebt_pkg::ebt_cmd_t  cmd = '0;                    // operands
  logic               enable_out_flag, busy, cmd_error, dt_rd, dt_wr, ee_rd, ee_wr;
  logic [16:0]        write_events;                // consumed events
  logic [15:0]        dt_addr, dt_wdata, dt_rdata, ee_wdata, ee_rdata;
  logic [13:0]        ee_addr;
  logic               power_fail = 1'b0, endurance_spent;  // supply loss pin, wear flag
  ebt_pkg::ebt_cmd_t  retain = '{8'h03, 8'h01, 16'h0200};  // retained area
  ebt_pkg::ebt_word_t exp_q [$];                   // expected words, oldest first
  int                 n_errors = 0, checks = 0, cyc = 0;
  logic [31:0]        rnd = 32'h7D9F9E16;          // lfsr state
  logic [1:0]         bad_v [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  logic [7:0]         bad_s [5] = '{8'h0A, 8'h00, 8'h60, 8'h00, 8'h00};
  logic [7:0]         bad_c [5] = '{8'h01, 8'h03, 8'h01, 8'h09, 8'h00};

  ebt_top ebt_top_i (.core_clk(core_clk), .rst(rst), .variant(variant), .scan_tick(scan_tick),
    .eeprom_block_read(eeprom_block_read), .eeprom_block_write(eeprom_block_write),
    .cmd(cmd), .power_fail(power_fail), .to_program_mode(to_program_mode), .retain_cmd(retain),
    .enable_out_flag(enable_out_flag), .busy(busy), .cmd_error(cmd_error),
    .endurance_spent(endurance_spent), .write_events(write_events), .dt_rd(dt_rd), .dt_wr(dt_wr),
    .dt_addr(dt_addr), .dt_wdata(dt_wdata), .dt_rdata(dt_rdata), .ee_rd(ee_rd),
    .ee_wr(ee_wr), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rdata(ee_rdata));
  ebt_mem_model ebt_mem_model_i (.core_clk(core_clk), .dt_rd(dt_rd), .dt_wr(dt_wr),
    .dt_addr(dt_addr), .dt_wdata(dt_wdata), .dt_rdata(dt_rdata), .ee_rd(ee_rd),
    .ee_wr(ee_wr), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rdata(ee_rdata));

  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_word(input ebt_pkg::ebt_word_t got, input ebt_pkg::ebt_word_t exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // an unexpected word is compared with its inverse
  task automatic take(input ebt_pkg::ebt_word_t got);
    if (exp_q.size() == 0)
      cmp_word(got, ~got);
    else
      cmp_word(got, exp_q.pop_front());
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge core_clk);
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    exp_q.delete();
  endtask
  task automatic scan();
    @(negedge core_clk);
    scan_tick = 1'b1;
    @(negedge core_clk);
    scan_tick = 1'b0;
  endtask
  // register image expected from eeprom blocks st.. onward
  task automatic exp_read(input int st, input int cnt, input logic [15:0] base);
    for (int i = 0; i < cnt * 64; i++)
      exp_q.push_back('{dt_addr: base + 16'(i), ee_addr: '0,
                        data: ebt_mem_model_i.eep_mem[st * 64 + i]});
  endtask
  // eeprom image expected from one register block at base
  task automatic exp_write(input int st, input logic [15:0] base);
    for (int i = 0; i < 64; i++)
      exp_q.push_back('{dt_addr: '0, ee_addr: 14'(st * 64 + i),
                        data: ebt_mem_model_i.reg_mem[base + 16'(i)]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: every sink strobe consumes the oldest note
  always @(posedge core_clk) begin
    if (!rst && dt_wr) take('{dt_addr: dt_addr, ee_addr: '0, data: dt_wdata});
    if (!rst && ee_wr) take('{dt_addr: '0, ee_addr: ee_addr, data: ee_wdata});
  end
  // hang guard, far above the fewer than two thousand cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("timeout at %0t", $time);
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    for (int i = 0; i < 65536; i++) begin
      rnd = lfsr(rnd);
      ebt_mem_model_i.reg_mem[i] = rnd[15:0];
      if (i < 16384) ebt_mem_model_i.eep_mem[i] = rnd[31:16];
    end
    do_reset();
    cmp_val(17'({enable_out_flag, busy, cmd_error, endurance_spent}), 17'h0);
    // operands outside each variant's range are refused
    for (int k = 0; k < 5; k++) begin
      @(negedge core_clk);
      variant = bad_v[k];
      cmd = '{first_operand: bad_s[k], block_count_operand: bad_c[k], dt_start: 16'h0100};
      eeprom_block_read = 1'b1;
      scan();
      repeat (4) @(posedge core_clk);
      cmp_val(17'(cmd_error), 17'h1);
      cmp_val(17'(enable_out_flag), 17'h0);
      @(negedge core_clk);
      eeprom_block_read = 1'b0;
      repeat (2) @(posedge core_clk);
    end
    $display("range test done");
    // read at the small variant's limits, then a rerun on the next scan
    rnd = lfsr(rnd);
    @(negedge core_clk);
    variant = 2'h0;
    cmd = '{first_operand: 8'h09, block_count_operand: 8'h02, dt_start: rnd[15:0]};
    eeprom_block_read = 1'b1;
    for (int r = 0; r < 2; r++) begin
      exp_read(9, 2, cmd.dt_start);
      scan();
      for (n = 0; n < 20 && !(busy === 1'b1); n++) @(posedge core_clk);
      for (n = 0; n < 1000 && !(busy === 1'b0); n++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      cmp_val(17'(exp_q.size()), 17'h0);
      cmp_val(17'({enable_out_flag, cmd_error}), 17'h2);
    end
    @(negedge core_clk);
    eeprom_block_read = 1'b0;
    repeat (3) @(posedge core_clk);
    cmp_val(17'(enable_out_flag), 17'h0);
    $display("read test done");
    // one write edge moves one block; programming time keeps the flag low
    rnd = lfsr(rnd);
    @(negedge core_clk);
    variant = 2'h1;
    cmd = '{first_operand: 8'h5F, block_count_operand: 8'h01, dt_start: rnd[15:0]};
    exp_write(95, cmd.dt_start);
    eeprom_block_write = 1'b1;
    for (n = 0; n < 1000 && exp_q.size() > 0; n++) @(posedge core_clk);
    repeat (300) @(posedge core_clk);
    cmp_val(17'({busy, enable_out_flag}), 17'h2);
    cmp_val(17'(exp_q.size()), 17'h0);
    do_reset();
    eeprom_block_write = 1'b0;
    cmp_val(17'({busy, enable_out_flag}), 17'h0);
    $display("write test done");
    // each run to program change consumes one write event
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      to_program_mode = 1'b1;
      @(negedge core_clk);
      to_program_mode = 1'b0;
      repeat (3) @(posedge core_clk);
      cmp_val(write_events, 17'(k + 1));
    end
    $display("event test done");
    // power loss saves the retained area once, flag not raised
    exp_write(3, retain.dt_start);
    @(negedge core_clk);
    power_fail = 1'b1;
    repeat (300) @(posedge core_clk);
    cmp_val(17'(exp_q.size()), 17'h0);
    cmp_val(17'({busy, enable_out_flag, cmd_error}), 17'h4);
    $display("save test done");
    end_sim();
  end
endmodule
